// ---- irq_src_pkg.sv ----
/*
 * irq_src_pkg: constants, register map, vector slots and carrier structs
 * for the interrupt source logic.
 * assumes: one 100 MHz clock; the core and peripherals share it.
 */
package irq_src_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_VEC     = 44;       // peripheral vectors 0..43
  localparam int NUM_EXT     = 6;        // external request pins
  localparam int NUM_COLL    = 3;        // serial channels with collision request
  localparam int ADDR_W      = 24;
  localparam int LVL_W       = 3;
  localparam int NEST_DEPTH  = 8;

  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL    = 12'h000;  // [0] address match enable
  localparam logic [11:0] OFS_MATCH   = 12'h004;  // match address
  localparam logic [11:0] OFS_EXTCFG  = 12'h008;  // 3 bits per ext pin
  localparam logic [11:0] OFS_SERMODE = 12'h00c;  // 2 bits per serial channel
  localparam logic [11:0] OFS_PEND_LO = 12'h010;  // pending 31..0, write 1 clears
  localparam logic [11:0] OFS_PEND_HI = 12'h014;  // pending 43..32
  localparam logic [11:0] OFS_STATUS  = 12'h018;
  localparam logic [11:0] OFS_PRIO    = 12'h100;  // one word per vector
  localparam logic [11:0] OFS_PRIO_END = 12'h1ac;

  // ext pin config field: bit0 level sense, bit1 high/rising, bit2 both edges
  localparam int EXT_LEVEL = 0;
  localparam int EXT_HIGH  = 1;
  localparam int EXT_BOTH  = 2;
  localparam int EXT_FW    = 3;
  // serial channel collision slot mode
  localparam logic [1:0] SER_COLL = 2'h0;
  localparam logic [1:0] SER_TWI  = 2'h1;
  localparam logic [1:0] SER_SS   = 2'h2;
  localparam int SER_FW = 2;

  // ------------------------------------------------------------
  // vector slots
  // ------------------------------------------------------------
  localparam int VEC_COLL0  = 4;
  localparam int VEC_DMA0   = 8;
  localparam int VEC_TA0    = 12;
  localparam int VEC_AD     = 24;
  localparam int VEC_KEY    = 25;
  localparam int VEC_EXT0   = 35;
  localparam logic [5:0] VEC_SWITCH_LIM = 6'h20; // int vectors below switch stack

  // ------------------------------------------------------------
  // instruction kinds reported by the core
  // ------------------------------------------------------------
  localparam logic [2:0] OP_NONE  = 3'h0;
  localparam logic [2:0] OP_ILL   = 3'h1;  // illegal_op_trap
  localparam logic [2:0] OP_INTO  = 3'h2;  // overflow trap
  localparam logic [2:0] OP_BRK   = 3'h3;  // breakpoint_op
  localparam logic [2:0] OP_DEBUGGER_BREAK_OP  = 3'h4;  // debugger_break_op
  localparam logic [2:0] OP_INT   = 3'h5;  // software interrupt with number
  localparam logic [2:0] OP_OFLAG = 3'h6;  // arithmetic family updating overflow

  // source classes on the take port
  localparam logic [3:0] SRC_RESET = 4'h0;
  localparam logic [3:0] SRC_WDT   = 4'h1;
  localparam logic [3:0] SRC_NMI   = 4'h2;
  localparam logic [3:0] SRC_MATCH = 4'h3;
  localparam logic [3:0] SRC_STEP  = 4'h4;
  localparam logic [3:0] SRC_ILL   = 4'h5;
  localparam logic [3:0] SRC_OVF   = 4'h6;
  localparam logic [3:0] SRC_BRK   = 4'h7;
  localparam logic [3:0] SRC_DEBUGGER_BREAK_OP  = 4'h8;
  localparam logic [3:0] SRC_INT   = 4'h9;
  localparam logic [3:0] SRC_PERI  = 4'ha;

  typedef struct packed {
    logic              exec;      // one instruction retired
    logic [2:0]        op;
    logic [5:0]        int_num;
    logic [ADDR_W-1:0] pc;        // first byte of retired instruction
    logic              ovf_res;   // overflow result for OP_OFLAG
    logic              u_flag;
    logic              i_flag;
    logic [LVL_W-1:0]  ipl;
    logic              d_flag;
    logic              take_ack;  // core starts the offered sequence
    logic              reti;      // core returns from a handler
  } core_in_t;

  typedef struct packed {
    logic              req;
    logic [3:0]        src;
    logic [5:0]        vec;
    logic              nonmask;
    logic              clear_u;   // save U and select handler_stack_pointer
    logic              restore_v; // one-cycle: restore U from restore_u
    logic              restore_u;
  } take_out_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_OFFER = 2'b10
  } take_st_t;
endpackage

// ---- interrupt_source_logic.sv ----
/*
 * interrupt_source_logic: classifies software traps, special interrupts and
 * peripheral requests and offers one at a time to the core.
 * assumes: inputs synchronous to core_clk; AHB-Lite single word transfers.
 */
// How it works
// - maskable requests need I flag and priority rank; non-maskable bypass both
// - instruction-raised interrupts are all non-maskable
// - illegal-operation trap raises undefined-instruction interrupt
// - overflow trap raises overflow interrupt only when overflow flag is 1
// - arithmetic families update the overflow flag
// - breakpoint instruction raises the break interrupt
// - second breakpoint instruction raises debugger break
// - software interrupt takes vector 0..63 and raises it
// - vectors 0..43 shared with peripheral sources
// - software interrupt 0..31 saves U, clears it, restores on return
// - software interrupt 32..63 leaves U untouched
// - every peripheral entry saves and clears U
// - reset, NMI pin, watchdog, address match, single step are non-maskable
// - reset pin low resets the device
// - enabled match of executed address raises address-match interrupt
// - match only on instruction first byte
// - single-step flag raises an interrupt after each instruction
// - peripheral requests maskable, vectored 0..43
// - collision slot carries start/stop in two-wire mode, fault with slave select
// - any low key pin raises key-input interrupt
// - ext pins sense edge (rise/fall/both) or level (high/low)
// - separate sources for DMA, timers, serial tx/rx, converter
`timescale 1ns/1ns
module interrupt_source_logic #(
  parameter int NV = irq_src_pkg::NUM_VEC,
  parameter int NE = irq_src_pkg::NUM_EXT
) (
  input  wire logic                               core_clk,
  input  wire logic                               rst_b,
  input  wire logic                               ce,
  // ahb-lite slave
  input  wire logic                               hsel,
  input  wire logic [31:0]                        haddr,
  input  wire logic [1:0]                         htrans,
  input  wire logic                               hwrite,
  input  wire logic [2:0]                         hsize,
  input  wire logic [31:0]                        hwdata,
  input  wire logic                               hready,
  output logic      [31:0]                        hrdata,
  output logic                                    hreadyout,
  output logic                                    hresp,
  // core side
  input  irq_src_pkg::core_in_t                   core_in,
  output irq_src_pkg::take_out_t                  take_out,
  // request sources
  input  wire logic [NV-1:0]                      periph_req,
  input  wire logic [irq_src_pkg::NUM_COLL-1:0]   coll_evt,
  input  wire logic [irq_src_pkg::NUM_COLL-1:0]   startstop_evt,
  input  wire logic [irq_src_pkg::NUM_COLL-1:0]   fault_evt,
  input  wire logic                               wdt_evt,
  input  wire logic                               nmi_pin_b,
  input  wire logic [7:0]                         key_pins,
  input  wire logic [NE-1:0]                      ext_request_pins
);
  import irq_src_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  take_st_t                   st_r;
  logic                       match_en_r;
  logic [ADDR_W-1:0]          match_addr_r;
  logic [NE*EXT_FW-1:0]       ext_cfg_r;
  logic [NUM_COLL*SER_FW-1:0] ser_mode_r;
  logic [LVL_W-1:0]           prio_r [NV];
  logic [NV-1:0]              pend_r;
  logic                       ovf_r;
  logic                       rst_pend_r, wdt_pend_r, nmi_pend_r, match_pend_r, step_pend_r;
  logic                       ill_pend_r, ovf_pend_r, brk_pend_r, debugger_break_op_pend_r, int_pend_r;
  logic [5:0]                 int_num_r;
  logic                       nmi_prev_r;
  logic [NE-1:0]              ext_prev_r;
  logic [NEST_DEPTH-1:0]      sv_sw_r, sv_u_r;
  logic [$clog2(NEST_DEPTH+1)-1:0] sp_r;
  logic [3:0]                 off_src_r;
  logic [5:0]                 off_vec_r;
  logic                       off_nm_r, off_cu_r;
  logic                       rest_v_r, rest_u_r;
  // bus data phase
  logic                       dph_r, dwr_r;
  logic [11:0]                dadr_r;

  logic [NV-1:0]              src_set, clr_sw, clr_take;
  logic [NE-1:0]              ext_hit;
  logic                       nm_any, mk_hit, pick_nm, pick_cu;
  logic [3:0]                 pick_src;
  logic [5:0]                 pick_vec, best_vec;
  logic [LVL_W-1:0]           best_lvl;
  logic                       acc, wr_en;
  logic [31:0]                rd_mux;

  wire   exec    = core_in.exec;
  wire   prio_hit = dadr_r >= OFS_PRIO && dadr_r <= OFS_PRIO_END;
  wire   [5:0] prio_idx = 6'((dadr_r - OFS_PRIO) >> 2);
  // read side decodes the address phase so hrdata stands in the data phase
  wire   [11:0] radr = haddr[11:0];
  wire   rprio_hit = radr >= OFS_PRIO && radr <= OFS_PRIO_END;
  wire   [5:0] rprio_idx = 6'((radr - OFS_PRIO) >> 2);

  // ------------------------------------------------------------
  // request sources
  // ------------------------------------------------------------
  // external pin sensing per configured mode
  always_comb begin
    for (int p = 0; p < NE; p++) begin
      logic lvl, hi, both, rise, fall;
      lvl  = ext_cfg_r[p*EXT_FW+EXT_LEVEL];
      hi   = ext_cfg_r[p*EXT_FW+EXT_HIGH];
      both = ext_cfg_r[p*EXT_FW+EXT_BOTH];
      rise = ext_request_pins[p] & ~ext_prev_r[p];
      fall = ~ext_request_pins[p] & ext_prev_r[p];
      if (lvl) begin
        ext_hit[p] = (ext_request_pins[p] == hi);
      end else begin
        ext_hit[p] = both ? (rise | fall) : (hi ? rise : fall);
      end
    end
  end

  // gather every peripheral slot
  always_comb begin
    src_set = periph_req;
    for (int c = 0; c < NUM_COLL; c++) begin
      case (ser_mode_r[c*SER_FW +: SER_FW])
        SER_TWI: src_set[VEC_COLL0+c] = startstop_evt[c];
        SER_SS:  src_set[VEC_COLL0+c] = fault_evt[c];
        default: src_set[VEC_COLL0+c] = coll_evt[c];
      endcase
    end
    src_set[VEC_KEY] = periph_req[VEC_KEY] | ~&key_pins;
    for (int p = 0; p < NE; p++) begin
      src_set[VEC_EXT0+p] = periph_req[VEC_EXT0+p] | ext_hit[p];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      nmi_prev_r <= 1'b1;
      ext_prev_r <= '0;
    end else if (ce) begin
      nmi_prev_r <= nmi_pin_b;
      ext_prev_r <= ext_request_pins;
    end
  end

  // overflow flag follows the arithmetic families
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_r <= 1'b0;
    end else if (ce && exec && core_in.op == OP_OFLAG) begin
      ovf_r <= core_in.ovf_res;
    end
  end

  // ------------------------------------------------------------
  // selection
  // ------------------------------------------------------------
  // highest programmed level among pending peripheral slots
  always_comb begin
    best_lvl = '0;
    best_vec = '0;
    for (int v = 0; v < NV; v++) begin
      if (pend_r[v] && prio_r[v] > best_lvl) begin
        best_lvl = prio_r[v];
        best_vec = 6'(v);
      end
    end
    mk_hit = core_in.i_flag && best_lvl > core_in.ipl;
  end

  // fixed order among non-maskable, flags and level ignored
  always_comb begin
    nm_any   = 1'b1;
    pick_nm  = 1'b1;
    pick_cu  = 1'b1;
    pick_vec = '0;
    if (rst_pend_r)        pick_src = SRC_RESET;
    else if (wdt_pend_r)   pick_src = SRC_WDT;
    else if (nmi_pend_r)   pick_src = SRC_NMI;
    else if (ill_pend_r)   pick_src = SRC_ILL;
    else if (ovf_pend_r)   pick_src = SRC_OVF;
    else if (brk_pend_r)   pick_src = SRC_BRK;
    else if (debugger_break_op_pend_r)  pick_src = SRC_DEBUGGER_BREAK_OP;
    else if (int_pend_r) begin
      pick_src = SRC_INT;
      pick_vec = int_num_r;
      pick_cu  = int_num_r < VEC_SWITCH_LIM;
    end
    else if (match_pend_r) pick_src = SRC_MATCH;
    else if (step_pend_r)  pick_src = SRC_STEP;
    else begin
      nm_any   = 1'b0;
      pick_nm  = 1'b0;
      pick_src = SRC_PERI;
      pick_vec = best_vec;
    end
  end

  // ------------------------------------------------------------
  // offer to the core
  // ------------------------------------------------------------
  assign acc = (st_r == ST_OFFER) && core_in.take_ack;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= ST_IDLE;
      off_src_r <= SRC_RESET;
      off_vec_r <= '0;
      off_nm_r  <= 1'b0;
      off_cu_r  <= 1'b0;
    end else if (ce) begin
      case (st_r)
        ST_IDLE: begin
          if (nm_any || mk_hit) begin
            st_r      <= ST_OFFER;
            off_src_r <= pick_src;
            off_vec_r <= pick_vec;
            off_nm_r  <= pick_nm;
            off_cu_r  <= pick_cu;
          end
        end
        ST_OFFER: begin
          if (core_in.take_ack) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // saved U stack, restored on return
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sv_sw_r  <= '0;
      sv_u_r   <= '0;
      sp_r     <= '0;
      rest_v_r <= 1'b0;
      rest_u_r <= 1'b0;
    end else if (ce) begin
      rest_v_r <= 1'b0;
      if (acc && sp_r < NEST_DEPTH) begin
        sv_sw_r[sp_r[$clog2(NEST_DEPTH)-1:0]] <= off_cu_r;
        sv_u_r[sp_r[$clog2(NEST_DEPTH)-1:0]]  <= core_in.u_flag;
        sp_r <= sp_r + 1'b1;
      end else if (core_in.reti && sp_r != '0) begin
        rest_v_r <= sv_sw_r[sp_r[$clog2(NEST_DEPTH)-1:0] - 1'b1];
        rest_u_r <= sv_u_r[sp_r[$clog2(NEST_DEPTH)-1:0] - 1'b1];
        sp_r     <= sp_r - 1'b1;
      end
    end
  end

  always_comb begin
    take_out.req       = st_r == ST_OFFER;
    take_out.src       = off_src_r;
    take_out.vec       = off_vec_r;
    take_out.nonmask   = off_nm_r;
    take_out.clear_u   = off_cu_r;
    take_out.restore_v = rest_v_r;
    take_out.restore_u = rest_u_r;
  end

  // ------------------------------------------------------------
  // pending flags: a new event wins over its clear
  // ------------------------------------------------------------
  always_comb begin
    clr_take = '0;
    if (acc && off_src_r == SRC_PERI) clr_take[off_vec_r] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_r <= '0;
    end else if (ce) begin
      pend_r <= (pend_r & ~clr_take & ~clr_sw) | src_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pend_r   <= 1'b1;
      wdt_pend_r   <= 1'b0;
      nmi_pend_r   <= 1'b0;
      match_pend_r <= 1'b0;
      step_pend_r  <= 1'b0;
      ill_pend_r   <= 1'b0;
      ovf_pend_r   <= 1'b0;
      brk_pend_r   <= 1'b0;
      debugger_break_op_pend_r  <= 1'b0;
      int_pend_r   <= 1'b0;
      int_num_r    <= '0;
    end else if (ce) begin
      rst_pend_r   <= rst_pend_r & ~(acc && off_src_r == SRC_RESET);
      wdt_pend_r   <= (wdt_pend_r & ~(acc && off_src_r == SRC_WDT)) | wdt_evt;
      nmi_pend_r   <= (nmi_pend_r & ~(acc && off_src_r == SRC_NMI)) | (nmi_prev_r & ~nmi_pin_b);
      match_pend_r <= (match_pend_r & ~(acc && off_src_r == SRC_MATCH))
                      | (exec && match_en_r && core_in.pc == match_addr_r);
      step_pend_r  <= (step_pend_r & ~(acc && off_src_r == SRC_STEP)) | (exec && core_in.d_flag);
      ill_pend_r   <= (ill_pend_r & ~(acc && off_src_r == SRC_ILL)) | (exec && core_in.op == OP_ILL);
      ovf_pend_r   <= (ovf_pend_r & ~(acc && off_src_r == SRC_OVF))
                      | (exec && core_in.op == OP_INTO && ovf_r);
      brk_pend_r   <= (brk_pend_r & ~(acc && off_src_r == SRC_BRK)) | (exec && core_in.op == OP_BRK);
      debugger_break_op_pend_r  <= (debugger_break_op_pend_r & ~(acc && off_src_r == SRC_DEBUGGER_BREAK_OP)) | (exec && core_in.op == OP_DEBUGGER_BREAK_OP);
      int_pend_r   <= (int_pend_r & ~(acc && off_src_r == SRC_INT)) | (exec && core_in.op == OP_INT);
      if (exec && core_in.op == OP_INT) int_num_r <= core_in.int_num;
    end
  end

  // ------------------------------------------------------------
  // ahb-lite register slave
  // ------------------------------------------------------------
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign wr_en     = ce && dph_r && dwr_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dph_r  <= 1'b0;
      dwr_r  <= 1'b0;
      dadr_r <= '0;
    end else if (ce && hready) begin
      dph_r  <= hsel && htrans[1] && hsize == 3'h2;
      dwr_r  <= hwrite;
      dadr_r <= haddr[11:0];
    end
  end

  // write-one-to-clear of pending slots
  always_comb begin
    clr_sw = '0;
    if (wr_en && dadr_r == OFS_PEND_LO) clr_sw[31:0] = hwdata;
    if (wr_en && dadr_r == OFS_PEND_HI) clr_sw[NV-1:32] = hwdata[NV-33:0];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      match_en_r   <= 1'b0;
      match_addr_r <= '0;
      ext_cfg_r    <= '0;
      ser_mode_r   <= '0;
    end else if (wr_en) begin
      if (dadr_r == OFS_CTRL)    match_en_r   <= hwdata[0];
      if (dadr_r == OFS_MATCH)   match_addr_r <= hwdata[ADDR_W-1:0];
      if (dadr_r == OFS_EXTCFG)  ext_cfg_r    <= hwdata[NE*EXT_FW-1:0];
      if (dadr_r == OFS_SERMODE) ser_mode_r   <= hwdata[NUM_COLL*SER_FW-1:0];
    end
  end

  // priority levels, zero keeps a slot out
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int v = 0; v < NV; v++) prio_r[v] <= '0;
    end else if (wr_en && prio_hit) begin
      prio_r[prio_idx] <= hwdata[LVL_W-1:0];
    end
  end

  // read mux on the address-phase address, unmapped reads as zero;
  // a read right behind a write to the same word returns the old value
  always_comb begin
    rd_mux = '0;
    case (radr)
      OFS_CTRL:    rd_mux[0] = match_en_r;
      OFS_MATCH:   rd_mux[ADDR_W-1:0] = match_addr_r;
      OFS_EXTCFG:  rd_mux[NE*EXT_FW-1:0] = ext_cfg_r;
      OFS_SERMODE: rd_mux[NUM_COLL*SER_FW-1:0] = ser_mode_r;
      OFS_PEND_LO: rd_mux = pend_r[31:0];
      OFS_PEND_HI: rd_mux[NV-33:0] = pend_r[NV-1:32];
      OFS_STATUS:  rd_mux[15:0] = {off_vec_r, off_src_r, sp_r[3:0], ovf_r, st_r == ST_OFFER};
      default:     if (rprio_hit) rd_mux[LVL_W-1:0] = prio_r[rprio_idx];
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= '0;
    end else if (ce && hready && hsel && htrans[1] && !hwrite && hsize == 3'h2) begin
      hrdata <= rd_mux;                                                // held until the next read
    end
  end

endmodule // interrupt_source_logic

// ---- irq_src_props.sv ----
/* checker on the ports of interrupt_source_logic.
   assumes: bound onto the design; single clock core_clk. */
`timescale 1ns/1ns
module irq_src_props (
  input wire logic             core_clk,
  input wire logic             rst_b,
  input wire logic             ce,
  input wire logic             hresp,
  input wire logic             hreadyout,
  input irq_src_pkg::core_in_t  core_in,
  input irq_src_pkg::take_out_t take_out
);
  import irq_src_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  okay_resp_a: assert property (hresp == 1'b0) else $error("hresp not okay");
  ready_ce_a: assert property (hreadyout == ce) else $error("hreadyout differs from ce");
  brk_offer_a: assert property (ce && core_in.exec && core_in.op == OP_BRK && !take_out.req
    |-> ##[1:4] take_out.req && take_out.src == SRC_BRK) else $error("break not offered");
  ill_offer_a: assert property (ce && core_in.exec && core_in.op == OP_ILL && !take_out.req
    |-> ##[1:4] take_out.req && take_out.src == SRC_ILL) else $error("illegal op not offered");
  trap_nonmask_a: assert property (take_out.req && take_out.src != SRC_PERI
    |-> take_out.nonmask) else $error("special offer maskable");
  peri_mask_a: assert property (take_out.req && take_out.src == SRC_PERI
    |-> !take_out.nonmask && take_out.clear_u && take_out.vec < 6'd44) else $error("bad peripheral offer");
  int_stack_a: assert property (take_out.req && take_out.src == SRC_INT
    |-> take_out.clear_u == (take_out.vec < VEC_SWITCH_LIM)) else $error("bad stack select");
  offer_hold_a: assert property (take_out.req && !core_in.take_ack
    |=> take_out.req && $stable(take_out.src) && $stable(take_out.vec)) else $error("offer dropped");
  ack_drop_a: assert property (ce && take_out.req && core_in.take_ack |=> !take_out.req)
    else $error("offer kept after ack");
  cover property (take_out.req && take_out.src == SRC_INT && take_out.vec > 6'd31);
  cover property (take_out.req && take_out.src == SRC_PERI);
  cover property (take_out.req && take_out.src == SRC_OVF);
endmodule // irq_src_props
bind interrupt_source_logic irq_src_props u_props (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
  .hresp(hresp), .hreadyout(hreadyout), .core_in(core_in), .take_out(take_out));

// ---- core_model.sv ----
/* processor core model: accepts every offer, at once or after a delay.
   assumes: take_out registered on core_clk. */
`timescale 1ns/1ns
module core_model (
  input wire logic              core_clk,
  input wire logic              rst_b,
  input wire logic              slow,
  input irq_src_pkg::take_out_t take_out,
  output logic                  take_ack
);
  import irq_src_pkg::*;
  logic [2:0] wait_r;
  // one-cycle ack pulse, delayed by three cycles when slow
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      take_ack <= 1'b0;
      wait_r <= 3'h0;
    end else if (take_out.req && !take_ack && (wait_r == 3'h3 || !slow)) begin
      take_ack <= 1'b1;
      wait_r <= 3'h0;
    end else begin
      take_ack <= 1'b0;
      wait_r <= take_out.req ? wait_r + 3'h1 : 3'h0;
    end
  end
endmodule // core_model

// ---- tb.sv ----
/* self-checking bench for interrupt_source_logic.
   assumes: core_model answers offers; zero-wait ahb slave. */
`timescale 1ns/1ns
module tb;
  import irq_src_pkg::*;
  logic core_clk = 0, rst_b = 0, ce = 1, hsel = 0, hwrite = 0, wdt_evt = 0, nmi_pin_b = 1, slow = 0;
  logic hready, hreadyout, hresp, ack;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rng = 32'hd1917767;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, zc = 0, sse = 0, fe = 0;
  logic [43:0] periph_req = 0;
  logic [7:0] key_pins = 8'hff;
  logic [5:0] ext_request_pins = 0;
  core_in_t ci = '0, cin;
  take_out_t to;
  int failures = 0, checks_done = 0;
  assign hready = hreadyout;
  always #5 core_clk = ~core_clk;
  always_comb begin
    cin = ci;
    cin.take_ack = ack;
  end
  interrupt_source_logic DUT (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_in(cin), .take_out(to), .periph_req(periph_req),
    .coll_evt(zc), .startstop_evt(sse), .fault_evt(fe), .wdt_evt(wdt_evt), .nmi_pin_b(nmi_pin_b),
    .key_pins(key_pins), .ext_request_pins(ext_request_pins));
  core_model u_core (.core_clk(core_clk), .rst_b(rst_b), .slow(slow), .take_out(to), .take_ack(ack));
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic finish_test();
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // one ahb single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, a};
    do @(posedge core_clk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic ins(input logic [2:0] op, input logic [5:0] n, input logic ov);
    @(posedge core_clk);
    {ci.exec, ci.op, ci.int_num, ci.ovf_res} <= {1'b1, op, n, ov};
    @(posedge core_clk);
    {ci.exec, ci.op} <= {1'b0, OP_NONE};
  endtask
  // waits for an offer, compares it, waits until the core took it
  task automatic offer(input logic [3:0] s, input logic [5:0] v, input logic nm, input logic cu);
    int n;
    n = 0;
    while (to.req !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(to.req === 1'b1 && to.src === s && to.nonmask === nm && ((s != SRC_INT && s != SRC_PERI) ||
      (to.vec === v && to.clear_u === cu)), "wrong offer");
    while (to.req === 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask
  task automatic none_for();
    repeat (6) begin
      @(posedge core_clk);
      #1 chk(to.req === 1'b0, "unexpected offer");
    end
  endtask
  initial begin
    #100000 failures++;
    finish_test();
  end
  // main sequence
  initial begin
    logic [31:0] q;
    logic [5:0] v;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    offer(SRC_RESET, 6'h0, 1'b1, 1'b0);
    ins(OP_ILL, 6'h0, 1'b0);
    offer(SRC_ILL, 6'h0, 1'b1, 1'b0);
    ins(OP_BRK, 6'h0, 1'b0);
    offer(SRC_BRK, 6'h0, 1'b1, 1'b0);
    ins(OP_DEBUGGER_BREAK_OP, 6'h0, 1'b0);
    offer(SRC_DEBUGGER_BREAK_OP, 6'h0, 1'b1, 1'b0);
    ins(OP_OFLAG, 6'h0, 1'b0);
    ins(OP_INTO, 6'h0, 1'b0);
    none_for();
    ins(OP_OFLAG, 6'h0, 1'b1);
    ins(OP_INTO, 6'h0, 1'b0);
    offer(SRC_OVF, 6'h0, 1'b1, 1'b0);
    for (int i = 0; i < 10; i++) begin
      q = xs();
      v = (i == 0) ? 6'd0 : (i == 1) ? 6'd31 : (i == 2) ? 6'd32 : (i == 3) ? 6'd63 : q[5:0];
      slow <= q[8];
      ins(OP_INT, v, 1'b0);
      offer(SRC_INT, v, 1'b1, v < 6'd32);
    end
    @(posedge core_clk) wdt_evt <= 1'b1;
    @(posedge core_clk) wdt_evt <= 1'b0;
    offer(SRC_WDT, 6'h0, 1'b1, 1'b0);
    nmi_pin_b <= 1'b0;
    offer(SRC_NMI, 6'h0, 1'b1, 1'b0);
    nmi_pin_b <= 1'b1;
    ci.d_flag <= 1'b1;
    ins(OP_NONE, 6'h0, 1'b0);
    ci.d_flag <= 1'b0;
    offer(SRC_STEP, 6'h0, 1'b1, 1'b0);
    bus(1'b0, 32'h800, 32'h0, q);
    chk(q === 32'h0, "unmapped read not zero");
    bus(1'b1, 32'(OFS_MATCH), 32'h1234, q);
    bus(1'b1, 32'(OFS_CTRL), 32'h1, q);
    bus(1'b0, 32'(OFS_MATCH), 32'h0, q);
    chk(q === 32'h1234, "match readback");
    ci.pc <= 24'h001234;
    ins(OP_NONE, 6'h0, 1'b0);
    offer(SRC_MATCH, 6'h0, 1'b1, 1'b0);
    bus(1'b1, 32'(OFS_CTRL), 32'h0, q);
    ins(OP_NONE, 6'h0, 1'b0);
    none_for();
    // ch0 two-wire, ch1 slave select, ch2 collision
    bus(1'b1, 32'(OFS_SERMODE), 32'h9, q);
    @(posedge core_clk) {fe, sse, zc, key_pins[2], ext_request_pins[0]} <= {9'o335, 2'b01};
    @(posedge core_clk) {fe, sse, zc, key_pins[2], ext_request_pins[0]} <= {9'o0, 2'b10};
    bus(1'b0, 32'(OFS_PEND_LO), 32'h0, q);
    chk(q === 32'h0200_0070, "pending low slots");
    bus(1'b0, 32'(OFS_PEND_HI), 32'h0, q);
    chk(q === 32'h8, "pending high slots");
    bus(1'b1, 32'(OFS_PEND_LO), 32'hffff_ffff, q);
    bus(1'b0, 32'(OFS_PEND_LO), 32'h0, q);
    chk(q === 32'h0, "pending not cleared");
    q = xs();
    v = 6'd17 + 6'(q % 7);
    bus(1'b1, 32'(OFS_PRIO) + {24'h0, v, 2'b00}, 32'h3, q);
    @(posedge core_clk) periph_req[v] <= 1'b1;
    @(posedge core_clk) periph_req[v] <= 1'b0;
    none_for();
    {ci.i_flag, ci.ipl} <= {1'b1, 3'h3};
    none_for();
    ci.ipl <= 3'h0;
    offer(SRC_PERI, v, 1'b0, 1'b1);
    finish_test();
  end
endmodule // tb
